// File: pkg/core_int_map.svh
// Purpose: register offsets, field layout and reset values of the per-core interrupt block
// Assumes: Avalon-MM with 32-bit data, byte addresses, one aligned word per register
// Notes:   each core occupies a 0x20-byte group; registers sit at fixed offsets in the group
`ifndef CORE_INT_MAP_SVH
`define CORE_INT_MAP_SVH

// ==========================================================================
// address layout
`define CI_ADDR_W          8
`define CI_CORE_STRIDE     8'h20
`define CI_OFS_RX_MASK     5'h00
`define CI_OFS_TX_MASK     5'h04
`define CI_OFS_MISC_MASK   5'h08
`define CI_OFS_THR_MASK    5'h0C
`define CI_OFS_THR_STAT    5'h10
`define CI_OFS_RX_STAT     5'h14
`define CI_OFS_TX_STAT     5'h18
`define CI_OFS_MISC_STAT   5'h1C

// ==========================================================================
// fields and reset values
`define CI_FIELD_MSB       7
`define CI_FIELD_W         8
`define CI_MASK_RESET      8'h00
`define CI_UNMAPPED_RDATA  32'h0000_0000

`endif

// File: pkg/core_int_pkg.sv
// Purpose: shared types of the per-core interrupt block
// Assumes: core_int_map.svh supplies the numbers
// Notes:   three cores, four interrupt classes each
package core_int_pkg;
`include "core_int_map.svh"

   localparam int NUM_CORES = 3;

   typedef logic [`CI_FIELD_MSB:0] int_vec_t;

   typedef enum logic [1:0]
   {
      CLASS_RX,
      CLASS_TX,
      CLASS_MISC,
      CLASS_THR
   } int_class_t;

endpackage : core_int_pkg

// File: pkg/core_gate_if.sv
// Purpose: carries one core's masks in and masked vectors out of the gating unit
// Assumes: all signals on sys_clk
// Notes:   masked vectors are combinational from masks and raw inputs
`timescale 1ns/1ps
interface core_gate_if;
   import core_int_pkg::*;

   int_vec_t   rx_mask;
   int_vec_t   tx_mask;
   int_vec_t   misc_mask;
   int_vec_t   thr_mask;
   int_vec_t   rx_masked;
   int_vec_t   tx_masked;
   int_vec_t   misc_masked;
   int_vec_t   thr_masked;

   modport regs
   (
      output rx_mask,
      output tx_mask,
      output misc_mask,
      output thr_mask,
      input  rx_masked,
      input  tx_masked,
      input  misc_masked,
      input  thr_masked
   );

   modport gate
   (
      input  rx_mask,
      input  tx_mask,
      input  misc_mask,
      input  thr_mask,
      output rx_masked,
      output tx_masked,
      output misc_masked,
      output thr_masked
   );
endinterface : core_gate_if

// File: rtl/core_int_gate.sv
// Purpose: per-bit gating of raw interrupt vectors by one core's masks
// Assumes: raw vectors synchronous to sys_clk
// Notes:   pure combinational; pulses are registered in the parent
`timescale 1ns/1ps
module core_int_gate
   import core_int_pkg::*;
(
   core_gate_if.gate      gif,
   input  wire int_vec_t  rx_raw,
   input  wire int_vec_t  tx_raw,
   input  wire int_vec_t  misc_raw,
   input  wire int_vec_t  thr_raw
);

   // ==========================================================================
   // masked vectors, one bit per source
   assign gif.rx_masked   = rx_raw & gif.rx_mask;       // see [R1] see [R5]
   assign gif.tx_masked   = tx_raw & gif.tx_mask;       // see [R2] see [R6]
   assign gif.misc_masked = misc_raw & gif.misc_mask;   // see [R3]
   assign gif.thr_masked  = thr_raw & gif.thr_mask;     // see [R8] see [R4]

endmodule : core_int_gate

// File: rtl/core_int_ctrl.sv
// Purpose: per-core interrupt enable masks, masked status and interrupt pulses
// Assumes: raw vectors are levels synchronous to sys_clk; Avalon-MM slave
// Notes:   pulse outputs are registered, one cycle behind the raw inputs
//
// Overview of operation
// [R1] receive mask gates raw receive onto pulse
// [R2] transmit mask gates raw transmit onto pulse
// [R3] misc mask gates misc sources onto pulse
// [R4] threshold status shows enabled active threshold
// [R5] receive status shows enabled active receive
// [R6] transmit status shows enabled active transmit
// [R7] bits 31-8 always read zero
// [R8] threshold mask gates raw threshold onto pulse
// [R9] pulse is OR of masked status
//
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "core_int_map.svh"
module core_int_ctrl
   import core_int_pkg::*;
(
   input  wire logic                        sys_clk,
   input  wire logic                        sys_rst,
   input  wire logic [`CI_ADDR_W-1:0]       avs_address,
   input  wire logic                        avs_read,
   input  wire logic                        avs_write,
   input  wire logic [31:0]                 avs_writedata,
   input  wire logic [3:0]                  avs_byteenable,
   output logic      [31:0]                 avs_readdata,
   output logic                             avs_waitrequest,
   input  wire logic [NUM_CORES*8-1:0]      rx_raw,
   input  wire logic [NUM_CORES*8-1:0]      tx_raw,
   input  wire logic [NUM_CORES*8-1:0]      misc_raw,
   input  wire logic [NUM_CORES*8-1:0]      thr_raw,
   output logic      [NUM_CORES-1:0]        core_receive_int_pulse,
   output logic      [NUM_CORES-1:0]        core_transmit_int_pulse,
   output logic      [NUM_CORES-1:0]        core_misc_int_pulse,
   output logic      [NUM_CORES-1:0]        core_receive_threshold_int_pulse
);

   // ==========================================================================
   // bus decode
   // every access completes one cycle after it is presented: waitrequest is
   // high in the first cycle and low in the second, when read data is valid.
   // a write lands only at the edge that ends the second cycle, which is the one
   // edge at which the master considers the transfer done.
   logic        ack_r;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;

   wire         access      = avs_read | avs_write;
   wire  [2:0]  core_sel    = 3'(avs_address[`CI_ADDR_W-1:5]);
   wire  [4:0]  reg_ofs     = avs_address[4:0];
   wire         core_ok     = (core_sel < 3'(NUM_CORES));
   wire         wr_commit   = avs_write & ack_r & core_ok & avs_byteenable[0];

   assign avs_waitrequest = access & ~ack_r;
   assign avs_readdata    = rdata_r;

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         ack_r <= 1'b0;
      else
         ack_r <= access & ~ack_r;
   end

   // ==========================================================================
   // per-core masks and gating
   int_vec_t rx_stat   [NUM_CORES];
   int_vec_t tx_stat   [NUM_CORES];
   int_vec_t misc_stat [NUM_CORES];
   int_vec_t thr_stat  [NUM_CORES];
   int_vec_t rx_mask_v [NUM_CORES];
   int_vec_t tx_mask_v [NUM_CORES];
   int_vec_t misc_mask_v [NUM_CORES];
   int_vec_t thr_mask_v  [NUM_CORES];

   genvar c;
   generate
      for (c = 0; c < NUM_CORES; c++)
      begin : g_core
         core_gate_if gif ();

         int_vec_t core_receive_int_mask_r;
         int_vec_t core_transmit_int_mask_r;
         int_vec_t core_misc_int_mask_r;
         int_vec_t core_receive_threshold_int_mask_r;

         // a write only lands on its core's group and only when lane 0 is on,
         // since the 8-bit fields live entirely in the low byte
         wire sel = wr_commit & (core_sel == 3'(c));

         always_ff @(posedge sys_clk)
         begin
            if (sys_rst)
            begin
               core_receive_int_mask_r           <= `CI_MASK_RESET;
               core_transmit_int_mask_r          <= `CI_MASK_RESET;
               core_misc_int_mask_r              <= `CI_MASK_RESET;
               core_receive_threshold_int_mask_r <= `CI_MASK_RESET;
            end
            else if (sel)
            begin
               if (reg_ofs == `CI_OFS_RX_MASK)
                  core_receive_int_mask_r <= avs_writedata[`CI_FIELD_MSB:0];
               if (reg_ofs == `CI_OFS_TX_MASK)
                  core_transmit_int_mask_r <= avs_writedata[`CI_FIELD_MSB:0];
               if (reg_ofs == `CI_OFS_MISC_MASK)
                  core_misc_int_mask_r <= avs_writedata[`CI_FIELD_MSB:0];
               if (reg_ofs == `CI_OFS_THR_MASK)
                  core_receive_threshold_int_mask_r <= avs_writedata[`CI_FIELD_MSB:0];
            end
         end

         assign gif.rx_mask   = core_receive_int_mask_r;
         assign gif.tx_mask   = core_transmit_int_mask_r;
         assign gif.misc_mask = core_misc_int_mask_r;
         assign gif.thr_mask  = core_receive_threshold_int_mask_r;

         core_int_gate u_gate
         (
            .gif      (gif.gate),
            .rx_raw   (rx_raw[c*8 +: 8]),
            .tx_raw   (tx_raw[c*8 +: 8]),
            .misc_raw (misc_raw[c*8 +: 8]),
            .thr_raw  (thr_raw[c*8 +: 8])
         );

         assign rx_stat[c]     = gif.rx_masked;     // see [R5]
         assign tx_stat[c]     = gif.tx_masked;     // see [R6]
         assign misc_stat[c]   = gif.misc_masked;
         assign thr_stat[c]    = gif.thr_masked;    // see [R4]
         assign rx_mask_v[c]   = core_receive_int_mask_r;
         assign tx_mask_v[c]   = core_transmit_int_mask_r;
         assign misc_mask_v[c] = core_misc_int_mask_r;
         assign thr_mask_v[c]  = core_receive_threshold_int_mask_r;

         // registered so the cores see glitch-free levels
         always_ff @(posedge sys_clk)
         begin
            if (sys_rst)
            begin
               core_receive_int_pulse[c]           <= 1'b0;
               core_transmit_int_pulse[c]          <= 1'b0;
               core_misc_int_pulse[c]              <= 1'b0;
               core_receive_threshold_int_pulse[c] <= 1'b0;
            end
            else
            begin
               core_receive_int_pulse[c]           <= |gif.rx_masked;   // see [R9] see [R1]
               core_transmit_int_pulse[c]          <= |gif.tx_masked;   // see [R9] see [R2]
               core_misc_int_pulse[c]              <= |gif.misc_masked; // see [R9] see [R3]
               core_receive_threshold_int_pulse[c] <= |gif.thr_masked;  // see [R9] see [R8]
            end
         end
      end
   endgenerate

   // ==========================================================================
   // read mux
   wire [1:0] core_idx = core_sel[1:0];

   always_comb
   begin
      rdata_nxt = `CI_UNMAPPED_RDATA;
      if (core_ok)
      begin
         unique case (reg_ofs)
            `CI_OFS_RX_MASK:   rdata_nxt = {24'h000000, rx_mask_v[core_idx]};   // see [R7]
            `CI_OFS_TX_MASK:   rdata_nxt = {24'h000000, tx_mask_v[core_idx]};
            `CI_OFS_MISC_MASK: rdata_nxt = {24'h000000, misc_mask_v[core_idx]};
            `CI_OFS_THR_MASK:  rdata_nxt = {24'h000000, thr_mask_v[core_idx]};
            `CI_OFS_THR_STAT:  rdata_nxt = {24'h000000, thr_stat[core_idx]};    // see [R4]
            `CI_OFS_RX_STAT:   rdata_nxt = {24'h000000, rx_stat[core_idx]};     // see [R5]
            `CI_OFS_TX_STAT:   rdata_nxt = {24'h000000, tx_stat[core_idx]};     // see [R6]
            `CI_OFS_MISC_STAT: rdata_nxt = {24'h000000, misc_stat[core_idx]};
            default:           rdata_nxt = `CI_UNMAPPED_RDATA;
         endcase
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         rdata_r <= `CI_UNMAPPED_RDATA;
      else if (avs_read & ~ack_r)
         rdata_r <= rdata_nxt;
   end

endmodule : core_int_ctrl

// File: verif/core_int_ctrl_chk.sv
// Purpose: port assertions of core_int_ctrl
// Assumes: one wait state; pulses lag inputs by one edge
// Notes:   raw-zero cases need no copy of the masks here
`timescale 1ns/1ps
module core_int_ctrl_chk
(
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [23:0] rx_raw,
   input wire logic [23:0] tx_raw,
   input wire logic [23:0] misc_raw,
   input wire logic [23:0] thr_raw,
   input wire logic [2:0]  core_receive_int_pulse,
   input wire logic [2:0]  core_transmit_int_pulse,
   input wire logic [2:0]  core_misc_int_pulse,
   input wire logic [2:0]  core_receive_threshold_int_pulse
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // ==========================================================
   // pulses
   AST_RX_IDLE: assert property (
      rx_raw[7:0] == 8'h00 |=> !core_receive_int_pulse[0])
      else $error("rx pulse without source");
   AST_TX_IDLE: assert property (
      tx_raw[15:8] == 8'h00 |=> !core_transmit_int_pulse[1])
      else $error("tx pulse without source");
   AST_MISC_IDLE: assert property (
      misc_raw[23:16] == 8'h00 |=> !core_misc_int_pulse[2])
      else $error("misc pulse without source");
   AST_THR_IDLE: assert property (
      thr_raw[7:0] == 8'h00 |=> !core_receive_threshold_int_pulse[0])
      else $error("threshold pulse without source");
   AST_RX_STEADY: assert property (
      (!avs_write && $stable(rx_raw))[*2] |=> $stable(core_receive_int_pulse))
      else $error("rx pulse moved with steady cause");
   // ==========================================================
   // reads
   AST_RX_STAT: assert property (
      avs_read && avs_waitrequest && avs_address == 8'h14 && rx_raw[7:0] == 8'h00
      |=> avs_readdata == 32'h0)
      else $error("rx status set without source");
   AST_THR_STAT: assert property (
      avs_read && avs_waitrequest && avs_address == 8'h50 && thr_raw[23:16] == 8'h00
      |=> avs_readdata == 32'h0)
      else $error("threshold status set without source");
   AST_HIGH_ZERO: assert property (
      avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   // status and pulse of one core are sampled from the same masked vector
   AST_RX_PULSE_STAT: assert property (
      avs_read && avs_waitrequest && avs_address == 8'h14
      |=> core_receive_int_pulse[0] == (|avs_readdata[7:0]))
      else $error("rx pulse disagrees with rx status");
endmodule : core_int_ctrl_chk

bind core_int_ctrl core_int_ctrl_chk chk_u (.sys_clk, .sys_rst, .avs_address, .avs_read,
   .avs_write, .avs_readdata, .avs_waitrequest, .rx_raw, .tx_raw, .misc_raw, .thr_raw,
   .core_receive_int_pulse, .core_transmit_int_pulse, .core_misc_int_pulse,
   .core_receive_threshold_int_pulse);

// File: verif/core_int_sink.sv
// Purpose: stands in for the three cores taking interrupt levels
// Assumes: levels are synchronous to sys_clk
// Notes:   a core acts once per rising level, so only rises are counted
`timescale 1ns/1ps
module core_int_sink
(
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic [11:0] levels,
   output int               rises
);
   logic [11:0] prev_r;
   always_ff @(posedge sys_clk)
   begin
      prev_r <= sys_rst ? 12'h000 : levels;
      rises  <= sys_rst ? 0 : rises + $countones(levels & ~prev_r);
   end
endmodule : core_int_sink

// File: verif/per_core_interrupt_mask_status_test.sv
// Purpose: regression of masks, status and pulses
// Assumes: one wait state per access
// Notes:   masks are tracked here so status and pulses are predicted
`timescale 1ns/1ps
module per_core_interrupt_mask_status_test;
   logic        sys_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [7:0]  adr = 8'h00;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [3:0]  be = 4'h0;
   logic [31:0] rdata;
   logic        wait_rq;
   logic [23:0] raw [4] = '{default: 24'h0};
   logic [2:0]  pul [4];
   logic [7:0]  m [4][3] = '{default: 8'h00};
   logic [31:0] q;
   int          bad_count = 0;
   int          checked = 0;
   int          rises;
   int          r0;

   initial forever #5 sys_clk = ~sys_clk;

   core_int_ctrl dut_u (.sys_clk, .sys_rst, .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wait_rq),
      .rx_raw(raw[0]), .tx_raw(raw[1]), .misc_raw(raw[2]), .thr_raw(raw[3]),
      .core_receive_int_pulse(pul[0]), .core_transmit_int_pulse(pul[1]),
      .core_misc_int_pulse(pul[2]), .core_receive_threshold_int_pulse(pul[3]));
   core_int_sink sink_u (.sys_clk, .sys_rst, .levels({pul[3], pul[2], pul[1], pul[0]}), .rises);

   // ==========================================================
   // tasks
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] e);
      @(posedge sys_clk);
      wr <= w;
      rd <= !w;
      adr <= a;
      wd <= d;
      be <= e;
      do
         @(posedge sys_clk);
      while (wait_rq !== 1'b0);
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus

   function automatic logic [7:0] loc(int c, int ofs);
      return 8'(c * 32 + ofs);
   endfunction : loc

   task automatic wmask(int c, int k, logic [7:0] v, logic [3:0] e);
      bus(1'b1, loc(c, k * 4), {24'hA5A5A5, v}, e);
      if (e[0])
         m[k][c] = v;
   endtask : wmask

   task automatic verify();
      logic [7:0] en;
      for (int c = 0; c < 3; c++)
         for (int k = 0; k < 4; k++)
         begin
            bus(1'b0, loc(c, k * 4), 32'h0, 4'hF);
            check("mask", q, {24'h0, m[k][c]});
            bus(1'b0, loc(c, k == 3 ? 16 : 20 + k * 4), 32'h0, 4'hF);
            en = raw[k][c*8 +: 8] & m[k][c];
            check("status", q, {24'h0, en});
            check("pulse", 32'(pul[k][c]), 32'(|en));
         end
   endtask : verify

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report

   // ==========================================================
   // tests
   initial
   begin
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      verify();
      for (int k = 0; k < 4; k++)
         raw[k] <= 24'h96C35A >> k;
      for (int c = 0; c < 3; c++)
         for (int k = 0; k < 4; k++)
            wmask(c, k, 8'hA5 ^ 8'(c * 16 + k), 4'hF);
      verify();
      // lane 0 off, unmapped core and read-only status must all leave state alone
      wmask(0, 0, 8'h0F, 4'hE);
      bus(1'b1, 8'h60, 32'hFF, 4'hF);
      bus(1'b0, 8'h60, 32'h0, 4'hF);
      check("unmapped", q, 32'h0);
      bus(1'b1, loc(1, 20), 32'hFF, 4'hF);
      verify();
      for (int k = 0; k < 4; k++)
         for (int b = 0; b < 8; b++)
         begin
            raw[k][15:8] <= ~(8'h01 << b);
            wmask(1, k, 8'h01 << b, 4'hF);
            verify();
            r0 = rises;
            raw[k][15:8] <= 8'h01 << b;
            verify();
            check("rises", rises - r0, 1);
         end
      final_report();
   end

   initial
   begin
      repeat (40000) @(posedge sys_clk);
      bad_count++;
      final_report();
   end
endmodule : per_core_interrupt_mask_status_test
